// *** rtl/twm_master.sv ***
/*
  Two-wire serial bus master: start, address, up to two data phases,
  repeated start and stop, sequenced entirely in hardware.
  Assumes open-drain pads with external pull-ups, a slave that never
  stretches the clock, and no other master on the bus.
*/
`timescale 1ns/10ps
`default_nettype none
// How it works
// - Two-pin master, clock and data lines
// - Bus rates 100, 400 and 800 kHz
// - Extra 1 MHz bus rate
// - Read-only transfer of 1 to 16 bytes
// - Write-only transfer of 1 to 16 bytes
// - Read then write, up to 16 each
// - Write then read, up to 16 each
// - No arbitration, no stretching, single master
// - Hardware runs whole transfer after setup
// - Lines only pulled low or released
// - Processor picks transfer type each time
module twm_master (
  input  wire logic                    ref_clk,
  input  wire logic                    rst,
  input  wire logic                    start,
  input  wire logic [1:0]              xfer_type,
  input  wire logic [1:0]              rate_sel,
  input  wire logic [6:0]              slave_addr,
  input  wire logic [twm_pkg::LEN_W-1:0] rd_len,
  input  wire logic [twm_pkg::LEN_W-1:0] wr_len,
  input  wire logic [7:0]              wr_data,
  input  wire logic                    wr_valid,
  output logic                         wr_ready,
  output logic [7:0]                   rd_data,
  output logic                         rd_valid,
  input  wire logic                    rd_ready,
  output logic                         busy,
  output logic                         done,
  output logic                         nack,
  output logic                         stretch_seen,
  input  wire logic                    scl_in,
  output logic                         scl_out,
  output logic                         scl_oe,
  input  wire logic                    sda_in,
  output logic                         sda_out,
  output logic                         sda_oe
);
  import twm_pkg::*;

  twm_state_t       state_reg, state_next;
  logic [1:0]       ph_reg,    ph_next;
  logic [Q_W-1:0]   div_reg,   div_next;
  logic [3:0]       bc_reg,    bc_next;
  logic [7:0]       sh_reg,    sh_next;
  logic             rx_reg,    rx_next;
  logic             adr_reg,   adr_next;
  logic             p2_reg,    p2_next;
  logic [LEN_W-1:0] rem_reg,   rem_next;
  logic [LEN_W-1:0] n1_reg,    n1_next;
  logic [LEN_W-1:0] n2_reg,    n2_next;
  logic [1:0]       type_reg,  type_next;
  logic [1:0]       rate_reg,  rate_next;
  logic [6:0]       sadr_reg,  sadr_next;
  logic             nack_reg,  nack_next;
  logic             fault_reg, fault_next;
  logic             done_reg,  done_next;
  logic             scl_reg,   scl_next;
  logic             sda_reg,   sda_next;
  logic [1:0]       scl_sync_reg;
  logic [1:0]       sda_sync_reg;
  logic             tick;
  logic             push;
  logic             combined;
  logic             space;

  twm_stream_if #(.W(8)) push_s ();
  twm_stream_if #(.W(8)) pull_s ();

  twm_buf #(.W(8)) u_rd_buf (
    .ref_clk (ref_clk),
    .rst     (rst),
    .in_s    (push_s),
    .out_s   (pull_s)
  );

  assign push_s.valid = push;
  assign push_s.data  = sh_reg;
  assign space        = push_s.ready;
  assign rd_valid     = pull_s.valid;
  assign rd_data      = pull_s.data;
  assign pull_s.ready = rd_ready;

  // Pads only ever pull low; the pull-ups make the high level
  assign scl_out      = 1'b0;
  assign sda_out      = 1'b0;
  assign scl_oe       = scl_reg;
  assign sda_oe       = sda_reg;
  assign busy         = (state_reg != ST_IDLE);
  assign done         = done_reg;
  assign nack         = nack_reg;
  assign stretch_seen = fault_reg;
  assign tick         = (div_reg == '0);
  assign combined     = (type_reg == XFER_RW) || (type_reg == XFER_WRRD);

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      scl_sync_reg <= 2'h3;
      sda_sync_reg <= 2'h3;
    end else begin
      scl_sync_reg <= {scl_sync_reg[0], scl_in};
      sda_sync_reg <= {sda_sync_reg[0], sda_in};
    end
  end

  always_comb begin
    state_next = state_reg;
    ph_next    = ph_reg;
    bc_next    = bc_reg;
    sh_next    = sh_reg;
    rx_next    = rx_reg;
    adr_next   = adr_reg;
    p2_next    = p2_reg;
    rem_next   = rem_reg;
    n1_next    = n1_reg;
    n2_next    = n2_reg;
    type_next  = type_reg;
    rate_next  = rate_reg;
    sadr_next  = sadr_reg;
    nack_next  = nack_reg;
    fault_next = fault_reg;
    done_next  = 1'b0;
    scl_next   = 1'b0;
    sda_next   = 1'b0;
    push       = 1'b0;
    wr_ready   = 1'b0;
    // Fixed quarter period; the free-running divider never waits on SCL
    div_next   = tick ? quarter(rate_reg) - Q_W'(1) : div_reg - Q_W'(1);
    case (state_reg)
      ST_IDLE: begin
        div_next = quarter(rate_sel) - Q_W'(1);
        ph_next  = '0;
        if (start) begin
          type_next  = xfer_type;
          rate_next  = rate_sel;
          sadr_next  = slave_addr;
          n1_next    = clamp_len(phase_reads(xfer_type, 1'b0) ? rd_len
                                                             : wr_len);
          n2_next    = clamp_len(phase_reads(xfer_type, 1'b1) ? rd_len
                                                             : wr_len);
          p2_next    = 1'b0;
          nack_next  = 1'b0;
          fault_next = 1'b0;
          state_next = ST_START;
        end
      end
      ST_START: begin
        // Same shape serves first and repeated start
        scl_next = (ph_reg == 2'h0) || (ph_reg == PH_LAST);
        sda_next = (ph_reg >= PH_SAMPLE);
        if (tick) begin
          ph_next = ph_reg + 2'h1;
          if (ph_reg == PH_LAST) begin
            bc_next    = '0;
            sh_next    = {sadr_reg, phase_reads(type_reg, p2_reg)};
            rx_next    = 1'b0;
            adr_next   = 1'b1;
            state_next = ST_BYTE;
          end
        end
      end
      ST_LOAD: begin
        // Clock held low while data or buffer room is awaited
        scl_next = 1'b1;
        div_next = quarter(rate_reg) - Q_W'(1);
        ph_next  = '0;
        bc_next  = '0;
        if (rx_reg && space) begin
          state_next = ST_BYTE;
        end else if (!rx_reg && wr_valid) begin
          wr_ready   = 1'b1;
          sh_next    = wr_data;
          state_next = ST_BYTE;
        end
      end
      ST_BYTE: begin
        scl_next = (ph_reg == 2'h0) || (ph_reg == PH_LAST);
        if (bc_reg != ACK_BIT)
          sda_next = !rx_reg && !sh_reg[7];
        else
          sda_next = rx_reg && (rem_reg != LEN_W'(1));
        if (tick) begin
          ph_next = ph_reg + 2'h1;
          if (ph_reg == PH_SAMPLE) begin
            if (!scl_sync_reg[1])
              fault_next = 1'b1;
            if (rx_reg && bc_reg != ACK_BIT)
              sh_next = {sh_reg[6:0], sda_sync_reg[1]};
            if (!rx_reg && bc_reg == ACK_BIT && sda_sync_reg[1])
              nack_next = 1'b1;
          end
          if (ph_reg == PH_LAST) begin
            if (bc_reg != ACK_BIT) begin
              bc_next = bc_reg + 4'h1;
              if (!rx_reg)
                sh_next = {sh_reg[6:0], 1'b0};
            end else begin
              push = rx_reg;
              if (nack_reg) begin
                state_next = ST_STOP;
              end else if (adr_reg) begin
                adr_next   = 1'b0;
                rx_next    = phase_reads(type_reg, p2_reg);
                rem_next   = p2_reg ? n2_reg : n1_reg;
                state_next = ST_LOAD;
              end else if (rem_reg != LEN_W'(1)) begin
                rem_next   = rem_reg - LEN_W'(1);
                state_next = ST_LOAD;
              end else if (combined && !p2_reg) begin
                p2_next    = 1'b1;
                state_next = ST_START;
              end else begin
                state_next = ST_STOP;
              end
            end
          end
        end
      end
      ST_STOP: begin
        scl_next = (ph_reg == 2'h0);
        sda_next = (ph_reg != PH_LAST);
        if (tick) begin
          ph_next = ph_reg + 2'h1;
          if (ph_reg == PH_LAST) begin
            done_next  = 1'b1;
            state_next = ST_IDLE;
          end
        end
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state_reg <= ST_IDLE;
      ph_reg    <= '0;
      div_reg   <= '0;
      bc_reg    <= '0;
      sh_reg    <= BYTE_RST;
      rx_reg    <= 1'b0;
      adr_reg   <= 1'b0;
      p2_reg    <= 1'b0;
      rem_reg   <= '0;
      n1_reg    <= '0;
      n2_reg    <= '0;
      type_reg  <= XFER_RD;
      rate_reg  <= RATE_100K;
      sadr_reg  <= '0;
      nack_reg  <= 1'b0;
      fault_reg <= 1'b0;
      done_reg  <= 1'b0;
      scl_reg   <= 1'b0;
      sda_reg   <= 1'b0;
    end else begin
      state_reg <= state_next;
      ph_reg    <= ph_next;
      div_reg   <= div_next;
      bc_reg    <= bc_next;
      sh_reg    <= sh_next;
      rx_reg    <= rx_next;
      adr_reg   <= adr_next;
      p2_reg    <= p2_next;
      rem_reg   <= rem_next;
      n1_reg    <= n1_next;
      n2_reg    <= n2_next;
      type_reg  <= type_next;
      rate_reg  <= rate_next;
      sadr_reg  <= sadr_next;
      nack_reg  <= nack_next;
      fault_reg <= fault_next;
      done_reg  <= done_next;
      scl_reg   <= scl_next;
      sda_reg   <= sda_next;
    end
  end

  // Checking helpers: cycles between ticks, bytes moved per transfer
  logic [Q_W-1:0]   gap_reg;
  logic [LEN_W:0]   rd_cnt_reg;
  logic [LEN_W:0]   wr_cnt_reg;

  always_ff @(posedge ref_clk) begin
    if (rst || tick)
      gap_reg <= '0;
    else
      gap_reg <= gap_reg + Q_W'(1);
    if (rst || (start && state_reg == ST_IDLE)) begin
      rd_cnt_reg <= '0;
      wr_cnt_reg <= '0;
    end else begin
      rd_cnt_reg <= rd_cnt_reg + (LEN_W+1)'(push);
      wr_cnt_reg <= wr_cnt_reg + (LEN_W+1)'(wr_ready);
    end
  end

  std_rate_a: assert property (@(posedge ref_clk) disable iff (rst)
    (tick && state_reg == ST_BYTE && ph_reg != 2'h0
     && rate_reg != RATE_1M) |-> (gap_reg == quarter(rate_reg) - Q_W'(1)))
    else $error("quarter period wrong at standard rate");

  fast_rate_a: assert property (@(posedge ref_clk) disable iff (rst)
    (tick && state_reg == ST_BYTE && ph_reg != 2'h0
     && rate_reg == RATE_1M) |-> (gap_reg == Q_1M - Q_W'(1)))
    else $error("quarter period wrong at 1 MHz");

  read_only_a: assert property (@(posedge ref_clk) disable iff (rst)
    (done_reg && !nack_reg && type_reg == XFER_RD)
    |-> (rd_cnt_reg == (LEN_W+1)'(n1_reg) && wr_cnt_reg == '0))
    else $error("read-only byte count wrong");

  write_only_a: assert property (@(posedge ref_clk) disable iff (rst)
    (done_reg && !nack_reg && type_reg == XFER_WR)
    |-> (wr_cnt_reg == (LEN_W+1)'(n1_reg) && rd_cnt_reg == '0))
    else $error("write-only byte count wrong");

  read_write_a: assert property (@(posedge ref_clk) disable iff (rst)
    (done_reg && !nack_reg && type_reg == XFER_RW)
    |-> (rd_cnt_reg == (LEN_W+1)'(n1_reg)
         && wr_cnt_reg == (LEN_W+1)'(n2_reg)))
    else $error("read-then-write byte count wrong");

  write_read_a: assert property (@(posedge ref_clk) disable iff (rst)
    (done_reg && !nack_reg && type_reg == XFER_WRRD)
    |-> (wr_cnt_reg == (LEN_W+1)'(n1_reg)
         && rd_cnt_reg == (LEN_W+1)'(n2_reg)))
    else $error("write-then-read byte count wrong");

  data_edge_a: assert property (@(posedge ref_clk) disable iff (rst)
    (state_reg == ST_BYTE && $changed(sda_oe) && $past(state_reg) == ST_BYTE)
    |-> scl_oe)
    else $error("data line moved while clock released");

  type_capture_a: assert property (@(posedge ref_clk) disable iff (rst)
    (start && state_reg == ST_IDLE)
    |=> (state_reg == ST_START && type_reg == $past(xfer_type)))
    else $error("transfer type not captured at start");

  one_stop_a: assert property (@(posedge ref_clk) disable iff (rst)
    ($rose(state_reg == ST_STOP) && !nack_reg && combined) |-> p2_reg)
    else $error("stop issued before second phase");
endmodule // twm_master
`default_nettype wire

// *** common/twm_pkg.sv ***
/*
  Shared constants, types and decode functions of the two-wire master.
  Assumes a 25 MHz core clock; every bus timing is derived from it.
*/
package twm_pkg;
  localparam int CLK_HZ      = 25_000_000;
  localparam int RATE_100K_HZ = 100_000;
  localparam int RATE_400K_HZ = 400_000;
  localparam int RATE_800K_HZ = 800_000;
  localparam int RATE_1M_HZ   = 1_000_000;
  localparam int Q_W          = 7;
  // Quarter bit periods, rounded down so the bus never runs slow
  localparam logic [Q_W-1:0] Q_100K = Q_W'(CLK_HZ / (4 * RATE_100K_HZ));
  localparam logic [Q_W-1:0] Q_400K = Q_W'(CLK_HZ / (4 * RATE_400K_HZ));
  localparam logic [Q_W-1:0] Q_800K = Q_W'(CLK_HZ / (4 * RATE_800K_HZ));
  localparam logic [Q_W-1:0] Q_1M   = Q_W'(CLK_HZ / (4 * RATE_1M_HZ));
  localparam int LEN_W     = 5;
  localparam int MAX_BYTES = 16;
  localparam logic [1:0] XFER_RD   = 2'h0;
  localparam logic [1:0] XFER_WR   = 2'h1;
  localparam logic [1:0] XFER_RW   = 2'h2;
  localparam logic [1:0] XFER_WRRD = 2'h3;
  localparam logic [1:0] RATE_100K = 2'h0;
  localparam logic [1:0] RATE_400K = 2'h1;
  localparam logic [1:0] RATE_800K = 2'h2;
  localparam logic [1:0] RATE_1M   = 2'h3;
  localparam logic [3:0] ACK_BIT   = 4'h8;
  localparam logic [1:0] PH_SAMPLE = 2'h2;
  localparam logic [1:0] PH_LAST   = 2'h3;
  localparam logic [7:0] BYTE_RST  = 8'h00;

  typedef enum logic [4:0] {
    ST_IDLE  = 5'h01,
    ST_START = 5'h02,
    ST_LOAD  = 5'h04,
    ST_BYTE  = 5'h08,
    ST_STOP  = 5'h10
  } twm_state_t;

  function automatic logic [Q_W-1:0] quarter(input logic [1:0] rate);
    case (rate)
      RATE_100K: quarter = Q_100K;
      RATE_400K: quarter = Q_400K;
      RATE_800K: quarter = Q_800K;
      default:   quarter = Q_1M;
    endcase
  endfunction

  // Direction of the first or second phase of a transfer type
  function automatic logic phase_reads(input logic [1:0] xt,
                                       input logic p2);
    case (xt)
      XFER_RD: phase_reads = 1'b1;
      XFER_WR: phase_reads = 1'b0;
      XFER_RW: phase_reads = !p2;
      default: phase_reads = p2;
    endcase
  endfunction

  function automatic logic [LEN_W-1:0] clamp_len(input logic [LEN_W-1:0] n);
    if (n == '0)
      clamp_len = LEN_W'(1);
    else if (n > LEN_W'(MAX_BYTES))
      clamp_len = LEN_W'(MAX_BYTES);
    else
      clamp_len = n;
  endfunction
endpackage

// *** common/twm_stream_if.sv ***
/*
  Valid/ready byte stream between the master core and its buffer.
  Assumes both ends sit on the same clock.
*/
`timescale 1ns/10ps
`default_nettype none
interface twm_stream_if #(parameter int W = 8);
  logic         valid;
  logic         ready;
  logic [W-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface
`default_nettype wire

// *** rtl/twm_buf.sv ***
/*
  Two-entry buffer with registered output data.
  Assumes a synchronous active-high reset on ref_clk.
*/
`timescale 1ns/10ps
`default_nettype none
module twm_buf #(
  parameter int W = 8
) (
  input wire logic     ref_clk,
  input wire logic     rst,
  twm_stream_if.snk    in_s,
  twm_stream_if.src    out_s
);
  logic [W-1:0] head_reg,  head_next;
  logic [W-1:0] spare_reg, spare_next;
  logic         hv_reg,    hv_next;
  logic         sv_reg,    sv_next;

  // Full only when both entries hold data
  assign in_s.ready  = !sv_reg;
  assign out_s.valid = hv_reg;
  assign out_s.data  = head_reg;

  always_comb begin
    head_next  = head_reg;
    spare_next = spare_reg;
    hv_next    = hv_reg;
    sv_next    = sv_reg;
    if (hv_reg && out_s.ready) begin
      head_next = spare_reg;
      hv_next   = sv_reg;
      sv_next   = 1'b0;
    end
    if (in_s.valid && !sv_reg) begin
      if (!hv_next) begin
        head_next = in_s.data;
        hv_next   = 1'b1;
      end else begin
        spare_next = in_s.data;
        sv_next    = 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      head_reg  <= '0;
      spare_reg <= '0;
      hv_reg    <= 1'b0;
      sv_reg    <= 1'b0;
    end else begin
      head_reg  <= head_next;
      spare_reg <= spare_next;
      hv_reg    <= hv_next;
      sv_reg    <= sv_next;
    end
  end
endmodule // twm_buf
`default_nettype wire

// *** test/twm_slave_model.sv ***
/*
  Behavioural slave at the far end of the two-wire bus: logs the
  address and write bytes it receives and answers reads with a pattern.
  Assumes it sees the wired SCL and SDA levels, sampled on ref_clk.
*/
`timescale 1ns/10ps
`default_nettype none
module twm_slave_model (
  input  wire logic ref_clk,
  input  wire logic scl,
  input  wire logic sda,
  output logic      sda_pull
);
  logic [7:0] sh;
  logic [7:0] tx;
  logic       pscl     = 1'b1;
  logic       psda     = 1'b1;
  logic       addr_ph  = 1'b0;
  logic       rd_mode  = 1'b0;
  logic       acked    = 1'b0;
  logic [6:0] nak_addr = 7'h2a;
  int         bitn     = 0;
  int         n_rd     = 0;
  int         starts   = 0;
  int         stops    = 0;
  logic [7:0] log_q[$];

  initial sda_pull = 1'b0;

  // Only SDA is ever pulled; the clock line is left to the master
  always @(posedge ref_clk) begin
    if (scl && pscl && psda && !sda) begin
      starts++;
      // The clock falls once after a start before the first data bit
      bitn = -1;
      addr_ph = 1'b1;
      rd_mode = 1'b0;
      n_rd = 0;
      sda_pull <= 1'b0;
    end else if (scl && pscl && !psda && sda) begin
      stops++;
      addr_ph = 1'b0;
      rd_mode = 1'b0;
      sda_pull <= 1'b0;
    end else if (scl && !pscl) begin
      if (bitn < 8)
        sh = {sh[6:0], sda};
      else if (!addr_ph)
        acked = !sda;
    end else if (!scl && pscl) begin
      if (bitn == 7) begin
        bitn = 8;
        if (!rd_mode) begin
          log_q.push_back(sh);
          // An address matching nak_addr is always refused; every other address and write byte is acknowledged
          sda_pull <= !(addr_ph && sh[7:1] == nak_addr);
        end else begin
          sda_pull <= 1'b0;
        end
      end else if (bitn == 8) begin
        bitn = 0;
        if (addr_ph) begin
          acked = (sh[7:1] != nak_addr);
          rd_mode = sh[0];
        end
        addr_ph = 1'b0;
        if (rd_mode && acked) begin
          tx = 8'h5a ^ (8'(n_rd) * 8'h1d);
          n_rd++;
          sda_pull <= !tx[7];
        end else begin
          sda_pull <= 1'b0;
        end
      end else begin
        bitn++;
        sda_pull <= rd_mode ? !tx[7-bitn] : 1'b0;
      end
    end
    pscl = scl;
    psda = sda;
  end
endmodule // twm_slave_model
`default_nettype wire

// *** test/twm_master_tb.sv ***
/*
  Self-checking bench of the two-wire master against a slave model.
  Assumes the pads are open drain with pull-ups on both lines.
*/
`timescale 1ns/10ps
`default_nettype none
module twm_master_tb;
  import twm_pkg::*;
  logic             ref_clk    = 1'b0;
  logic             rst        = 1'b1;
  logic             start      = 1'b0;
  logic [1:0]       xfer_type  = 2'h0;
  logic [1:0]       rate_sel   = 2'h0;
  logic [6:0]       slave_addr = 7'h00;
  logic [LEN_W-1:0] rd_len     = '0;
  logic [LEN_W-1:0] wr_len     = '0;
  logic [7:0]       wr_data    = 8'h00;
  logic             wr_valid   = 1'b0;
  logic             rd_ready   = 1'b0;
  logic             wr_ready;
  logic [7:0]       rd_data;
  logic             rd_valid;
  logic             busy;
  logic             done;
  logic             nack;
  logic             stretch_seen;
  logic             scl_out;
  logic             scl_oe;
  logic             sda_out;
  logic             sda_oe;
  logic             sda_pull;
  wire              scl_w;
  wire              sda_w;
  logic [15:0]      lfsr_reg   = 16'h08dd;
  logic [15:0]      rv;
  logic             stall      = 1'b0;
  logic [7:0]       wq[$];
  logic [7:0]       rgot[$];
  int               wr_idx     = 0;
  int               hi_cnt     = 0;
  int               last_hi    = 0;
  int               error_cnt  = 0;
  int               tests_run  = 0;
  int               ri;
  int               ti;
  int               ln;

  always #20 ref_clk = ~ref_clk;

  // Wired-AND with pull-ups; the slave never holds the clock
  assign scl_w = scl_oe ? scl_out : 1'b1;
  assign sda_w = (sda_oe ? sda_out : 1'b1) & !sda_pull;

  twm_master i_dut (
    .ref_clk(ref_clk), .rst(rst), .start(start), .xfer_type(xfer_type),
    .rate_sel(rate_sel), .slave_addr(slave_addr), .rd_len(rd_len),
    .wr_len(wr_len), .wr_data(wr_data), .wr_valid(wr_valid),
    .wr_ready(wr_ready), .rd_data(rd_data), .rd_valid(rd_valid),
    .rd_ready(rd_ready), .busy(busy), .done(done), .nack(nack),
    .stretch_seen(stretch_seen), .scl_in(scl_w), .scl_out(scl_out),
    .scl_oe(scl_oe), .sda_in(sda_w), .sda_out(sda_out), .sda_oe(sda_oe)
  );

  twm_slave_model i_slave (
    .ref_clk(ref_clk), .scl(scl_w), .sda(sda_w), .sda_pull(sda_pull)
  );

  function automatic logic [15:0] rnd();
    lfsr_reg = {lfsr_reg[14:0],
                lfsr_reg[15] ^ lfsr_reg[13] ^ lfsr_reg[12] ^ lfsr_reg[10]};
    return lfsr_reg;
  endfunction

  function automatic logic [7:0] rd_pat(input int i);
    return 8'h5a ^ (8'(i) * 8'h1d);
  endfunction

  function automatic int q_of(input logic [1:0] r);
    case (r)
      RATE_100K: return int'(Q_100K);
      RATE_400K: return int'(Q_400K);
      RATE_800K: return int'(Q_800K);
      default:   return int'(Q_1M);
    endcase
  endfunction

  function automatic int clip(input int n);
    return (n == 0) ? 1 : (n > MAX_BYTES) ? MAX_BYTES : n;
  endfunction

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic finish_test();
    $display("checks %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // Stream ends: writes held until taken, reads stalled at random
  always @(posedge ref_clk) begin
    logic       tk;
    logic [15:0] sr;
    tk = (wr_valid === 1'b1 && wr_ready === 1'b1);
    if (tk)
      wr_idx++;
    if (rd_valid === 1'b1 && rd_ready === 1'b1)
      rgot.push_back(rd_data);
    #1;
    sr = rnd();
    wr_data <= (wr_idx < wq.size()) ? wq[wr_idx] : 8'h00;
    wr_valid <= (wr_idx < wq.size()) && ((wr_valid && !tk) || sr[0]);
    rd_ready <= !stall && sr[1];
  end

  always @(posedge ref_clk) begin
    if (scl_w === 1'b1)
      hi_cnt <= hi_cnt + 1;
    else begin
      if (hi_cnt != 0)
        last_hi <= hi_cnt;
      hi_cnt <= 0;
    end
  end

  task automatic run(input logic [1:0] t, input logic [1:0] r,
                     input logic [6:0] a, input int rn, input int wn,
                     input logic enak);
    int         n;
    int         nr;
    int         nw;
    logic       rf;
    logic       two;
    logic [7:0] e[$];
    rf = (t == XFER_RD) || (t == XFER_RW);
    two = t[1] && !enak;
    nr = (t == XFER_WR || enak) ? 0 : clip(rn);
    nw = (t == XFER_RD || enak) ? 0 : clip(wn);
    wq.delete();
    for (n = 0; n < wn; n++)
      wq.push_back(8'(rnd()));
    wr_idx = 0;
    rgot.delete();
    i_slave.log_q.delete();
    i_slave.starts = 0;
    i_slave.stops = 0;
    @(posedge ref_clk);
    #1;
    xfer_type = t;
    rate_sel = r;
    slave_addr = a;
    rd_len = LEN_W'(rn);
    wr_len = LEN_W'(wn);
    start = 1'b1;
    @(posedge ref_clk);
    #1;
    start = 1'b0;
    check(busy, 1'b1);
    n = 0;
    while (done !== 1'b1 && n < 60000) begin
      @(posedge ref_clk);
      #1;
      n++;
    end
    check(done, 1'b1);
    n = 0;
    while (rd_valid === 1'b1 && n < 100) begin
      @(posedge ref_clk);
      #1;
      n++;
    end
    e.push_back({a, rf});
    for (n = 0; n < nw && !rf; n++)
      e.push_back(wq[n]);
    if (two)
      e.push_back({a, !rf});
    for (n = 0; n < nw && rf && two; n++)
      e.push_back(wq[n]);
    check(i_slave.log_q.size(), e.size());
    for (n = 0; n < e.size() && n < i_slave.log_q.size(); n++)
      check(i_slave.log_q[n], e[n]);
    check(i_slave.starts, two ? 2 : 1);
    check(i_slave.stops, 1);
    check(rgot.size(), nr);
    for (n = 0; n < nr && n < rgot.size(); n++)
      check(rgot[n], rd_pat(n));
    check(wr_idx, nw);
    check(nack, enak);
    check(last_hi, 2 * q_of(r));
    check(stretch_seen, 1'b0);
    wq.delete();
  endtask

  initial begin
    repeat (100000) @(posedge ref_clk);
    error_cnt++;
    finish_test();
  end

  initial begin
    repeat (12) @(posedge ref_clk);
    #1;
    rst = 1'b0;
    check({busy, done, nack, stretch_seen}, 4'h0);
    check({scl_oe, sda_oe, rd_valid, wr_ready}, 4'h0);
    check({scl_out, sda_out}, 2'h0);
    for (ri = 0; ri < 4; ri++) begin
      for (ti = 0; ti < 4; ti++) begin
        rv = rnd();
        ln = (ri == 3) ? 16 : (ri == 0) ? 1 : 1 + int'(rv[9:8]);
        run(2'(ti), 2'(ri), {1'b1, rv[7:2]}, ln,
            (ri == 0) ? 1 : ln + int'(rv[10]), 1'b0);
      end
    end
    // Lengths outside 1..16 are clipped to the nearest end
    run(XFER_WRRD, RATE_1M, 7'h33, 0, 20, 1'b0);
    run(XFER_WR, RATE_1M, 7'h2a, 1, 4, 1'b1);
    stall = 1'b1;
    fork
      run(XFER_RD, RATE_1M, 7'h41, 16, 1, 1'b0);
      begin
        repeat (40) @(posedge ref_clk);
        #1;
        xfer_type = XFER_WR;
        start = 1'b1;
        @(posedge ref_clk);
        #1;
        start = 1'b0;
        repeat (3000) @(posedge ref_clk);
        stall = 1'b0;
      end
    join
    finish_test();
  end
endmodule // twm_master_tb
`default_nettype wire
